// file: pcstc_map.svh
// Register map, field positions, reset values and bus codes for the coding-sublayer bank
`ifndef PCSTC_MAP_SVH
`define PCSTC_MAP_SVH
`define PCSTC_IDX_COPY 16'h3000
`define PCSTC_IDX_CTL 16'h3900
`define PCSTC_IDX_STS 16'h3901
`define PCSTC_IDX_TSEL 16'h1904
`define PCSTC_CTL_RESET 15
`define PCSTC_CTL_LOOP 14
`define PCSTC_TSEL_HI 15
`define PCSTC_TSEL_LO 13
`define PCSTC_TSEL_RSVD 3'h3
`define PCSTC_STS_TXSEEN 11
`define PCSTC_STS_RXSEEN 10
`define PCSTC_STS_TXLIVE 9
`define PCSTC_STS_RXLIVE 8
`define PCSTC_STS_FAULT 7
`define PCSTC_STS_LINK 2
`define PCSTC_RESET_VAL 16'h0000
`define PCSTC_RESP_OKAY 2'h0
`define PCSTC_RESP_SLVERR 2'h2
`endif

// file: pcstc_pkg.sv
// Types shared by the coding-sublayer register bank
package pcstc_pkg;
    typedef logic [15:0] pcstc_word_t;
    typedef logic [2:0] pcstc_tsel_t;
    typedef enum logic [1:0] {
        PCSTC_W_COLLECT = 2'b00,
        PCSTC_W_EXEC = 2'b01,
        PCSTC_W_RESP = 2'b11
    } pcstc_wstate_t;
    typedef enum logic {
        PCSTC_R_IDLE = 1'b0,
        PCSTC_R_RESP = 1'b1
    } pcstc_rstate_t;
endpackage

// file: pcstc_regs.sv
// AXI4-Lite register bank for coding-sublayer control, status and line test select
`timescale 1ns/100ps
`include "pcstc_map.svh"

module pcstc_regs (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic tx_lpi_in,
    input wire logic rx_lpi_in,
    input wire logic fault_in,
    input wire logic link_up_in,
    input wire logic reset_done_in,
    output pcstc_pkg::pcstc_tsel_t test_mode_out,
    output logic sublayer_reset_out,
    output logic sublayer_loopback_out
);
    import pcstc_pkg::*;

    // Index match with leading digit dropped
    function automatic logic idx_hit(input logic [11:0] a, input logic [15:0] idx);
        idx_hit = (a == idx[11:0]);
    endfunction

    function automatic logic idx_known(input logic [11:0] a);
        idx_known = idx_hit(a, `PCSTC_IDX_COPY) || idx_hit(a, `PCSTC_IDX_CTL)
            || idx_hit(a, `PCSTC_IDX_STS) || idx_hit(a, `PCSTC_IDX_TSEL);
    endfunction

    pcstc_wstate_t wr_state_r;
    pcstc_rstate_t rd_state_r;
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] wr_idx_r;
    pcstc_word_t wdata_r;
    logic [1:0] wstrb_r;
    logic ctl_reset_r;
    logic ctl_loop_r;
    logic cpy_reset_r;
    logic cpy_loop_r;
    pcstc_tsel_t tsel_r;
    logic tx_seen_r;
    logic rx_seen_r;
    logic link_ll_r;
    logic wr_go;
    logic hi_en;
    logic lo_en;

    assign wr_go = (wr_state_r == PCSTC_W_EXEC);
    assign hi_en = wstrb_r[1];
    assign lo_en = wstrb_r[0];

    // Register read value
    function automatic pcstc_word_t rd_word(input logic [11:0] a);
        rd_word = `PCSTC_RESET_VAL;
        if (idx_hit(a, `PCSTC_IDX_CTL)) begin
            rd_word[`PCSTC_CTL_RESET] = ctl_reset_r;
            rd_word[`PCSTC_CTL_LOOP] = ctl_loop_r;
        end else if (idx_hit(a, `PCSTC_IDX_COPY)) begin
            rd_word[`PCSTC_CTL_RESET] = cpy_reset_r;
            rd_word[`PCSTC_CTL_LOOP] = cpy_loop_r;
        end else if (idx_hit(a, `PCSTC_IDX_STS)) begin
            rd_word[`PCSTC_STS_TXSEEN] = tx_seen_r;
            rd_word[`PCSTC_STS_RXSEEN] = rx_seen_r;
            rd_word[`PCSTC_STS_TXLIVE] = tx_lpi_in;
            rd_word[`PCSTC_STS_RXLIVE] = rx_lpi_in;
            rd_word[`PCSTC_STS_FAULT] = fault_in;
            rd_word[`PCSTC_STS_LINK] = link_ll_r;
        end else if (idx_hit(a, `PCSTC_IDX_TSEL)) begin
            rd_word[`PCSTC_TSEL_HI:`PCSTC_TSEL_LO] = tsel_r;
        end
    endfunction

    // Write address and data capture, in either order
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_r <= 1'b0;
            s_axi_awready_out <= 1'b1;
            wr_idx_r <= 12'h000;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_r <= 1'b1;
            s_axi_awready_out <= 1'b0;
            wr_idx_r <= s_axi_awaddr_in[13:2];
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_awready_out <= 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            w_held_r <= 1'b0;
            s_axi_wready_out <= 1'b1;
            wdata_r <= `PCSTC_RESET_VAL;
            wstrb_r <= 2'h0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_r <= 1'b1;
            s_axi_wready_out <= 1'b0;
            wdata_r <= s_axi_wdata_in[15:0];
            wstrb_r <= s_axi_wstrb_in[1:0];
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_wready_out <= 1'b1;
        end
    end

    // Write sequencing and response
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_state_r <= PCSTC_W_COLLECT;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `PCSTC_RESP_OKAY;
        end else begin
            case (wr_state_r)
                PCSTC_W_COLLECT: begin
                    if (aw_held_r && w_held_r) begin
                        wr_state_r <= PCSTC_W_EXEC;
                    end
                end
                PCSTC_W_EXEC: begin
                    wr_state_r <= PCSTC_W_RESP;
                    s_axi_bvalid_out <= 1'b1;
                    s_axi_bresp_out <= idx_known(wr_idx_r) ? `PCSTC_RESP_OKAY : `PCSTC_RESP_SLVERR;
                end
                PCSTC_W_RESP: begin
                    if (s_axi_bready_in) begin
                        s_axi_bvalid_out <= 1'b0;
                        wr_state_r <= PCSTC_W_COLLECT;
                    end
                end
                default: begin
                    wr_state_r <= PCSTC_W_COLLECT;
                    s_axi_bvalid_out <= 1'b0;
                end
            endcase
        end
    end

    // Read channel
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rd_state_r <= PCSTC_R_IDLE;
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `PCSTC_RESP_OKAY;
        end else begin
            case (rd_state_r)
                PCSTC_R_IDLE: begin
                    if (s_axi_arvalid_in) begin
                        rd_state_r <= PCSTC_R_RESP;
                        s_axi_arready_out <= 1'b0;
                        s_axi_rvalid_out <= 1'b1;
                        s_axi_rdata_out <= {16'h0000, rd_word(s_axi_araddr_in[13:2])};
                        s_axi_rresp_out <= idx_known(s_axi_araddr_in[13:2]) ?
                            `PCSTC_RESP_OKAY : `PCSTC_RESP_SLVERR;
                    end
                end
                PCSTC_R_RESP: begin
                    if (s_axi_rready_in) begin
                        rd_state_r <= PCSTC_R_IDLE;
                        s_axi_rvalid_out <= 1'b0;
                        s_axi_arready_out <= 1'b1;
                    end
                end
                default: begin
                    rd_state_r <= PCSTC_R_IDLE;
                end
            endcase
        end
    end

    // Control register and its copy
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_reset_r <= 1'b0;
            ctl_loop_r <= 1'b0;
        end else if (wr_go && hi_en && idx_hit(wr_idx_r, `PCSTC_IDX_CTL)) begin
            ctl_reset_r <= wdata_r[`PCSTC_CTL_RESET];
            ctl_loop_r <= wdata_r[`PCSTC_CTL_LOOP];
        end else if (reset_done_in) begin
            ctl_reset_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cpy_reset_r <= 1'b0;
            cpy_loop_r <= 1'b0;
        end else if (wr_go && hi_en && idx_hit(wr_idx_r, `PCSTC_IDX_COPY)) begin
            cpy_reset_r <= wdata_r[`PCSTC_CTL_RESET];
            cpy_loop_r <= wdata_r[`PCSTC_CTL_LOOP];
        end else if (reset_done_in) begin
            cpy_reset_r <= 1'b0;
        end
    end

    // Test mode select; reserved code is refused
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            tsel_r <= 3'h0;
        end else if (wr_go && hi_en && idx_hit(wr_idx_r, `PCSTC_IDX_TSEL)
            && wdata_r[`PCSTC_TSEL_HI:`PCSTC_TSEL_LO] != `PCSTC_TSEL_RSVD) begin
            tsel_r <= wdata_r[`PCSTC_TSEL_HI:`PCSTC_TSEL_LO];
        end
    end

    // Status flags; hardware event beats software write (set for idle flags, link-down clear for link flag)
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            tx_seen_r <= 1'b0;
        end else if (tx_lpi_in) begin
            tx_seen_r <= 1'b1;
        end else if (wr_go && hi_en && idx_hit(wr_idx_r, `PCSTC_IDX_STS) && !wdata_r[`PCSTC_STS_TXSEEN]) begin
            tx_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rx_seen_r <= 1'b0;
        end else if (rx_lpi_in) begin
            rx_seen_r <= 1'b1;
        end else if (wr_go && hi_en && idx_hit(wr_idx_r, `PCSTC_IDX_STS) && !wdata_r[`PCSTC_STS_RXSEEN]) begin
            rx_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            link_ll_r <= 1'b0;
        end else if (!link_up_in) begin
            link_ll_r <= 1'b0;
        end else if (wr_go && lo_en && idx_hit(wr_idx_r, `PCSTC_IDX_STS) && !wdata_r[`PCSTC_STS_LINK]) begin
            link_ll_r <= 1'b1;
        end
    end

    // Outputs to the coding sublayer
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            test_mode_out <= 3'h0;
            sublayer_reset_out <= 1'b0;
            sublayer_loopback_out <= 1'b0;
        end else begin
            test_mode_out <= tsel_r;
            sublayer_reset_out <= ctl_reset_r | cpy_reset_r;
            sublayer_loopback_out <= ctl_loop_r | cpy_loop_r;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence ctl_write_s;
        wr_go && hi_en && idx_hit(wr_idx_r, `PCSTC_IDX_CTL);
    endsequence

    sequence sts_read_s;
        rd_state_r == PCSTC_R_IDLE && s_axi_arvalid_in && idx_hit(s_axi_araddr_in[13:2], `PCSTC_IDX_STS);
    endsequence

    test_sel_a: assert property (
        (wr_go && hi_en && idx_hit(wr_idx_r, `PCSTC_IDX_TSEL)) |->
        ##2 test_mode_out == (($past(wdata_r[15:13], 2) == 3'h3) ? $past(tsel_r, 2) : $past(wdata_r[15:13], 2)))
        else $error("test mode select mismatch");

    reset_clear_a: assert property (
        ctl_reset_r && reset_done_in && !wr_go |=> !ctl_reset_r ##1 !sublayer_reset_out || cpy_reset_r)
        else $error("sublayer reset did not self-clear");

    loop_write_a: assert property (
        ctl_write_s |=> ctl_loop_r == $past(wdata_r[14]) ##1 sublayer_loopback_out == (ctl_loop_r | cpy_loop_r))
        else $error("loopback bit not written");

    copy_write_a: assert property (
        (wr_go && hi_en && idx_hit(wr_idx_r, `PCSTC_IDX_COPY)) |=>
        cpy_reset_r == $past(wdata_r[15]) && cpy_loop_r == $past(wdata_r[14]))
        else $error("copy control write lost");

    tx_sticky_a: assert property (
        tx_lpi_in |=> tx_seen_r [*1] ##0 (tx_seen_r || $past(wr_go)))
        else $error("transmit idle flag not set");

    rx_sticky_a: assert property (
        rx_lpi_in |=> rx_seen_r)
        else $error("receive idle flag not set");

    live_read_a: assert property (
        sts_read_s |=> s_axi_rvalid_out && s_axi_rdata_out[9] == $past(tx_lpi_in)
        && s_axi_rdata_out[8] == $past(rx_lpi_in) && s_axi_rdata_out[7] == $past(fault_in))
        else $error("live status bits wrong");

    link_low_a: assert property (
        !link_up_in |=> !link_ll_r)
        else $error("link flag did not latch low");

    rsvd_zero_a: assert property (
        sts_read_s |=> s_axi_rdata_out[31:12] == 20'h00000 && s_axi_rdata_out[6:3] == 4'h0
        && s_axi_rdata_out[1:0] == 2'h0)
        else $error("reserved status bits not zero");

    reset_zero_a: assert property (
        disable iff (1'b0) rst_in |=> !ctl_reset_r && !ctl_loop_r && !tx_seen_r && !link_ll_r)
        else $error("bank not zero after reset");
endmodule // pcstc_regs

// file: pcstc_regs_tb.sv
// Self-checking testbench for the coding-sublayer register bank
`timescale 1ns/100ps
`include "pcstc_map.svh"
module pcstc_regs_tb;
    import pcstc_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic tx_lpi = 1'b0, rx_lpi = 1'b0, fault = 1'b0, link_up = 1'b1, reset_done = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sl_reset, sl_loop;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    pcstc_tsel_t test_mode;
    int err_count = 0;
    int samples_checked = 0;
    logic [31:0] amap [5] = '{32'hc000, 32'he400, 32'he404, 32'h6410, 32'h0008};
    // Reference state of the bank
    logic cpy_l = 1'b0, ctl_l = 1'b0, txs = 1'b0, rxs = 1'b0, lk = 1'b0;
    pcstc_tsel_t tsel_m = 3'h0;

    always #4 clock_in = ~clock_in;

    pcstc_regs u_pcstc_regs (
        .clock_in(clock_in), .rst_in(rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .tx_lpi_in(tx_lpi), .rx_lpi_in(rx_lpi), .fault_in(fault), .link_up_in(link_up),
        .reset_done_in(reset_done), .test_mode_out(test_mode),
        .sublayer_reset_out(sl_reset), .sublayer_loopback_out(sl_loop)
    );

    task automatic stop_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        @(posedge clock_in);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {16'h0, d};
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock_in);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk({31'h0, n == 100}, 32'h0);
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge clock_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock_in);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        chk({31'h0, n == 100}, 32'h0);
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    function automatic logic [31:0] reg_exp(input int sel);
        case (sel)
            0: return {16'h0, 1'b0, cpy_l, 14'h0};
            1: return {16'h0, 1'b0, ctl_l, 14'h0};
            2: return {16'h0, 4'h0, txs, rxs, tx_lpi, rx_lpi, fault, 4'h0, lk, 2'h0};
            3: return {16'h0, tsel_m, 13'h0};
            default: return 32'h0;
        endcase
    endfunction

    initial begin
        #100000;
        err_count++;
        stop_test();
    end

    initial begin
        int i;
        int sel;
        logic [15:0] d;
        logic [3:0] s;
        void'($urandom(36));
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        // All zero after reset, link bit low although link is up
        for (i = 0; i < 4; i++) rd(amap[i], reg_exp(i), `PCSTC_RESP_OKAY);
        // Control reached with a different leading index nibble
        wr(32'h2400, 16'h7fff, 4'h3, `PCSTC_RESP_OKAY);
        ctl_l = 1'b1;
        rd(amap[1], reg_exp(1), `PCSTC_RESP_OKAY);
        chk({31'h0, sl_loop}, 32'h1);
        // Reset bit in both copies, cleared by sublayer completion
        for (i = 0; i < 2; i++) begin
            wr(amap[i], 16'hc000, 4'h3, `PCSTC_RESP_OKAY);
            cpy_l = 1'b1;
            rd(amap[i], reg_exp(i) | 32'h8000, `PCSTC_RESP_OKAY);
            chk({31'h0, sl_reset}, 32'h1);
            @(posedge clock_in);
            reset_done <= 1'b1;
            @(posedge clock_in);
            reset_done <= 1'b0;
            rd(amap[i], reg_exp(i), `PCSTC_RESP_OKAY);
            chk({31'h0, sl_reset}, 32'h0);
        end
        // Every test select code, reserved code kept out
        for (i = 0; i < 8; i++) begin
            wr(amap[3], {i[2:0], 13'h1fff}, 4'h3, `PCSTC_RESP_OKAY);
            if (i != 3) tsel_m = i[2:0];
            rd(amap[3], reg_exp(3), `PCSTC_RESP_OKAY);
            chk({29'h0, test_mode}, {29'h0, tsel_m});
        end
        // Random traffic with changing sublayer inputs
        for (i = 0; i < 100; i++) begin
            @(posedge clock_in);
            tx_lpi <= ($urandom % 4) == 0;
            rx_lpi <= ($urandom % 4) == 0;
            fault <= 1'($urandom);
            link_up <= ($urandom % 5) != 0;
            sel = $urandom % 5;
            d = 16'($urandom);
            s = 4'($urandom);
            if (sel < 2) d[15] = 1'b0;
            wr(amap[sel], d, s, (sel == 4) ? `PCSTC_RESP_SLVERR : `PCSTC_RESP_OKAY);
            if (sel == 0 && s[1]) cpy_l = d[14];
            if (sel == 1 && s[1]) ctl_l = d[14];
            if (sel == 2 && s[1] && !d[11]) txs = 1'b0;
            if (sel == 2 && s[1] && !d[10]) rxs = 1'b0;
            if (sel == 2 && s[0] && !d[2] && link_up) lk = 1'b1;
            if (sel == 3 && s[1] && d[15:13] != `PCSTC_TSEL_RSVD) tsel_m = d[15:13];
            txs = txs | tx_lpi;
            rxs = rxs | rx_lpi;
            if (!link_up) lk = 1'b0;
            rd(amap[sel], reg_exp(sel), (sel == 4) ? `PCSTC_RESP_SLVERR : `PCSTC_RESP_OKAY);
            rd(amap[2], reg_exp(2), `PCSTC_RESP_OKAY);
            chk({29'h0, test_mode}, {29'h0, tsel_m});
            chk({31'h0, sl_loop}, {31'h0, cpy_l | ctl_l});
        end
        stop_test();
    end
endmodule // pcstc_regs_tb
